// ---- led_host_model.sv ----
// Host model: drives the enable pulse line when the bench calls it.
// Assumes the bench passes every phase length in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
  input  wire logic CLOCK,
  output var  logic EN
);
  // ****************************************************************
  // Line drive
  // ****************************************************************
  // Low until power-up, so the device starts out in shutdown
  initial EN = 1'b0;

  // Hold one level for n samples, changing only just after an edge
  task automatic phase(input logic v, input int n);
    @(posedge CLOCK);
    EN <= v;
    repeat (n - 1) @(posedge CLOCK);
  endtask : phase

  // Burst of n falling edges that ends low; the caller ends the burst
  task automatic burst(input int n, input int ph);
    for (int i = 0; i < n; i++)
    begin
      phase(1'b0, ph);
      if (i < n - 1)
        phase(1'b1, ph);
    end
  endtask : burst
endmodule : led_host_model
`default_nettype wire

// ---- led_pulse_ctrl.sv ----
// Top of the pulse programmed four channel LED current controller.
// Assumes EN and all analog flags are synchronous to CLOCK.
//
// What this block does
// - EN low for 1.5 ms or more shuts the device down, shorter does not.
// - Shutdown clears all stored programming to default values.
// - Falling edges set the level register, which drives all four sinks.
// - The pump starts in 1X and stays there while all channels regulate.
// - A regulation shortfall moves the pump to 1.5X after 500 us filter.
// - In 1.5X the pump returns to 1X once the supply is sufficient.
// - A channel near the pump output is switched off with test current.
// - A disabled channel comes back once its pin drops below that level.
// - Over-temperature stops the outputs until the flag clears again.
// - The current has sixteen linear steps chosen by a 4-bit level.
// - A single falling edge in a burst selects full-scale current.
`timescale 1ns/1ps
`default_nettype none
module led_pulse_ctrl #(
  parameter int unsigned OFF_CYC   = led_pulse_pkg::OFF_CYC,
  parameter int unsigned APPLY_CYC = led_pulse_pkg::APPLY_CYC,
  parameter int unsigned FILT_CYC  = led_pulse_pkg::FILT_CYC
) (
  input  wire logic                            CLOCK,
  input  wire logic                            RST_N,
  input  wire logic                            EN,
  input  wire logic [led_pulse_pkg::NCH-1:0]   REG_OK,
  input  wire logic                            SUPPLY_OK,
  input  wire logic [led_pulse_pkg::NCH-1:0]   NEAR_VOUT,
  input  wire logic                            OVER_TEMP,
  output var  logic [led_pulse_pkg::NCH-1:0]   SINK_ON,
  output var  logic [led_pulse_pkg::NCH-1:0]   TEST_CURRENT,
  output var  logic [led_pulse_pkg::LVL_W-1:0] LEVEL,
  output var  logic                            PUMP_1P5X,
  output var  logic                            ACTIVE
);

  localparam int CW = led_pulse_pkg::CNT_W;
  localparam int NC = led_pulse_pkg::NCH;

  led_pulse_pkg::state_t  state_r;
  led_pulse_pkg::state_t  state_nxt;
  logic                   en_prev_r;
  logic [CW-1:0]          low_cnt_r;
  logic [CW-1:0]          low_cnt_nxt;
  logic [CW-1:0]          high_cnt_r;
  logic [CW-1:0]          high_cnt_nxt;
  logic [CW-1:0]          init_cnt_r;
  logic [CW-1:0]          init_cnt_nxt;
  logic [3:0]             pend_r;
  logic [3:0]             pend_nxt;
  logic                   pend_open_r;
  logic                   pend_open_nxt;
  logic [3:0]             level_r;
  logic [3:0]             level_nxt;
  logic [NC-1:0]          sink_r;
  logic [NC-1:0]          sink_nxt;
  logic [NC-1:0]          test_r;
  logic [NC-1:0]          test_nxt;
  logic                   fall;
  logic                   active_r;
  logic                   active_nxt;

  pump_if pif ();

  // ****************************************************************
  // Pulse decoder and power state
  // ****************************************************************
  assign fall = en_prev_r && !EN;

  // Edges are only counted in run, so pulses during setup are dropped
  always_comb
  begin
    state_nxt     = state_r;
    low_cnt_nxt   = '0;
    high_cnt_nxt  = '0;
    init_cnt_nxt  = '0;
    pend_nxt      = pend_r;
    pend_open_nxt = pend_open_r;
    level_nxt     = level_r;
    case (state_r)
      led_pulse_pkg::ST_SHUTDOWN:
      begin
        pend_nxt      = led_pulse_pkg::LEVEL_DEF;
        pend_open_nxt = 1'b0;
        level_nxt     = led_pulse_pkg::LEVEL_DEF;
        if (EN)
          state_nxt = led_pulse_pkg::ST_INIT;
      end
      led_pulse_pkg::ST_INIT, led_pulse_pkg::ST_RUN:
      begin
        if (!EN)
        begin
          if (low_cnt_r == CW'(OFF_CYC - 1))
            state_nxt = led_pulse_pkg::ST_SHUTDOWN;
          else
            low_cnt_nxt = low_cnt_r + 1'b1;
        end
        if (state_r == led_pulse_pkg::ST_INIT)
        begin
          if (init_cnt_r == CW'(led_pulse_pkg::SETUP_CYC - 1))
          begin
            if (EN)
              state_nxt = led_pulse_pkg::ST_RUN;
          end
          else
            init_cnt_nxt = init_cnt_r + 1'b1;
        end
        else
        begin
          // First edge loads full scale, later ones step down and wrap
          if (fall)
          begin
            pend_open_nxt = 1'b1;
            if (!pend_open_r)
              pend_nxt = led_pulse_pkg::LEVEL_FULL;
            else
              pend_nxt = pend_r - 4'h1;
          end
          else if (EN && pend_open_r)
          begin
            if (high_cnt_r == CW'(APPLY_CYC - 1))
            begin
              level_nxt     = pend_r;
              pend_open_nxt = 1'b0;
            end
            else
              high_cnt_nxt = high_cnt_r + 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt = led_pulse_pkg::ST_SHUTDOWN;
      end
    endcase
  end

  // Power-up looks like shutdown; a high EN then runs the setup delay
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state_r     <= led_pulse_pkg::ST_SHUTDOWN;
      en_prev_r   <= 1'b0;
      low_cnt_r   <= '0;
      high_cnt_r  <= '0;
      init_cnt_r  <= '0;
      pend_r      <= led_pulse_pkg::LEVEL_DEF;
      pend_open_r <= 1'b0;
      level_r     <= led_pulse_pkg::LEVEL_DEF;
    end
    else
    begin
      state_r     <= state_nxt;
      en_prev_r   <= EN;
      low_cnt_r   <= low_cnt_nxt;
      high_cnt_r  <= high_cnt_nxt;
      init_cnt_r  <= init_cnt_nxt;
      pend_r      <= pend_nxt;
      pend_open_r <= pend_open_nxt;
      level_r     <= level_nxt;
    end
  end

  // ****************************************************************
  // Channel enables
  // ****************************************************************
  // Test current stays on a parked channel so it can sense a return
  always_comb
  begin
    sink_nxt   = '0;
    test_nxt   = '0;
    active_nxt = (state_nxt == led_pulse_pkg::ST_RUN);
    for (int i = 0; i < NC; i++)
    begin
      if (state_nxt == led_pulse_pkg::ST_RUN && !OVER_TEMP)
      begin
        sink_nxt[i] = !NEAR_VOUT[i];
        test_nxt[i] = NEAR_VOUT[i];
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      sink_r   <= '0;
      test_r   <= '0;
      active_r <= 1'b0;
    end
    else
    begin
      sink_r   <= sink_nxt;
      test_r   <= test_nxt;
      active_r <= active_nxt;
    end
  end

  // ****************************************************************
  // Pump sequencer and outputs
  // ****************************************************************
  assign pif.run       = (state_r == led_pulse_pkg::ST_RUN) && !OVER_TEMP;
  assign pif.all_ok    = &(REG_OK | ~sink_r);
  assign pif.supply_ok = SUPPLY_OK;

  pump_ratio_ctrl #(
    .FILT_CYC (FILT_CYC)
  ) u_pump (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .pif   (pif)
  );

  assign SINK_ON      = sink_r;
  assign TEST_CURRENT = test_r;
  assign LEVEL        = level_r;
  assign PUMP_1P5X    = pif.ratio_1p5x;
  assign ACTIVE       = active_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_off_not_early: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (state_r == led_pulse_pkg::ST_SHUTDOWN
     && $past(state_r) != led_pulse_pkg::ST_SHUTDOWN)
    |-> $past(low_cnt_r) == CW'(OFF_CYC - 1) && !$past(EN))
    else $error("shutdown entered without the full low time");

  chk_shutdown_clear: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (state_r == led_pulse_pkg::ST_SHUTDOWN)
    |=> level_r == led_pulse_pkg::LEVEL_DEF && !pend_open_r)
    else $error("programming survived shutdown");

  chk_apply_delay: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (level_r != $past(level_r) && $past(state_r) == led_pulse_pkg::ST_RUN)
    |-> $past(high_cnt_r) == CW'(APPLY_CYC - 1) && $past(EN))
    else $error("level applied before the apply delay");

  chk_first_edge: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (fall && state_r == led_pulse_pkg::ST_RUN && !pend_open_r)
    |=> pend_r == led_pulse_pkg::LEVEL_FULL)
    else $error("first edge did not select full scale");

  chk_next_edge: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (fall && state_r == led_pulse_pkg::ST_RUN && pend_open_r)
    |=> pend_r == 4'($past(pend_r) - 4'h1))
    else $error("further edge did not step one level down");

  chk_sinks_run: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (SINK_ON != '0) |-> ACTIVE && !$past(OVER_TEMP))
    else $error("sinks driven outside normal run");

  chk_proximity: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (state_nxt == led_pulse_pkg::ST_RUN && !OVER_TEMP)
    |=> SINK_ON == ~$past(NEAR_VOUT) && TEST_CURRENT == $past(NEAR_VOUT))
    else $error("channel enable does not follow proximity flag");

  sequence s_enter_run;
    state_r == led_pulse_pkg::ST_INIT ##1 state_r == led_pulse_pkg::ST_RUN;
  endsequence

  chk_init_hold: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_enter_run |-> $past(init_cnt_r)
                    == CW'(led_pulse_pkg::SETUP_CYC - 1))
    else $error("run entered before the setup delay");

endmodule : led_pulse_ctrl
`default_nettype wire

// ---- led_pulse_ctrl_test.sv ----
// Self-checking bench for the pulse programmed LED current controller.
// Assumes the host model above and shortened apply, off and filter counts.
`timescale 1ns/1ps
`default_nettype none
module led_pulse_ctrl_test;
  // ****************************************************************
  // Setup
  // ****************************************************************
  localparam int OFF = 200;
  localparam int APL = 100;
  localparam int FLT = 100;
  logic       clock     = 1'b0;
  logic       rst_n     = 1'b0;
  logic       en;
  logic [3:0] reg_ok    = 4'hF;
  logic       supply_ok = 1'b0;
  logic [3:0] near      = 4'h0;
  logic       over_temp = 1'b0;
  logic [3:0] sink_on;
  logic [3:0] test_cur;
  logic [3:0] level;
  logic       pump;
  logic       active;
  int         n_errors  = 0;
  int         checks    = 0;
  int         cyc       = 0;
  int         exp_lvl   = 15;
  int         sizes[$]  = '{2, 16, 17, 1, 3};
  logic [31:0] seed     = 32'hDE96E4A6;
  logic [3:0] v;

  // Fixed half period of 10 ns
  always #10 clock = ~clock;

  led_host_model host (.CLOCK(clock), .EN(en));

  led_pulse_ctrl #(.OFF_CYC(OFF), .APPLY_CYC(APL), .FILT_CYC(FLT)) DUT (
    .CLOCK       (clock),
    .RST_N       (rst_n),
    .EN          (en),
    .REG_OK      (reg_ok),
    .SUPPLY_OK   (supply_ok),
    .NEAR_VOUT   (near),
    .OVER_TEMP   (over_temp),
    .SINK_ON     (sink_on),
    .TEST_CURRENT(test_cur),
    .LEVEL       (level),
    .PUMP_1P5X   (pump),
    .ACTIVE      (active)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // Compare once the edge's updates have landed
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    #1;
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // Program n edges; level must hold until the apply delay has run
  task automatic prog(input int n);
    int ph;
    seed = lfsr(seed);
    ph = 25 + int'(seed[3:0]);
    host.burst(n, ph);
    host.phase(1'b1, APL - 5);
    chk(level, 4'(exp_lvl));
    exp_lvl = 15 - ((n - 1) % 16);
    host.phase(1'b1, 10);
    chk(level, 4'(exp_lvl));
  endtask : prog

  // Hang guard: far above the expected run length
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    tick(4);
    rst_n <= 1'b1;
    chk(level, 4'hF);
    host.phase(1'b1, 400);
    chk({3'h0, active}, 4'h0);
    host.phase(1'b1, 110);
    chk({3'h0, active}, 4'h1);
    chk(sink_on, 4'hF);
    chk({3'h0, pump}, 4'h0);
    seed = lfsr(seed);
    sizes.push_back(1 + int'(seed[7:0]) % 17);
    foreach (sizes[i])
      prog(sizes[i]);
    // Proximity flags turn sinks into test currents and back
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      v = seed[3:0];
      @(posedge clock);
      near <= v;
      tick(2);
      chk(sink_on, ~v);
      chk(test_cur, v);
    end
    @(posedge clock);
    over_temp <= 1'b1;
    tick(2);
    chk(sink_on | test_cur, 4'h0);
    @(posedge clock);
    over_temp <= 1'b0;
    tick(2);
    chk(sink_on, ~v);
    // Regulation shortfall on a driven channel, then supply recovers
    @(posedge clock);
    near <= 4'h0;
    reg_ok <= 4'hE;
    tick(FLT - 5);
    chk({3'h0, pump}, 4'h0);
    tick(10);
    chk({3'h0, pump}, 4'h1);
    @(posedge clock);
    supply_ok <= 1'b1;
    tick(2);
    chk({3'h0, pump}, 4'h0);
    @(posedge clock);
    reg_ok <= 4'hF;
    supply_ok <= 1'b0;
    // A low just short of the off time is a single edge burst
    prog(4);
    host.phase(1'b0, OFF - 5);
    host.phase(1'b1, APL + 5);
    chk({3'h0, active}, 4'h1);
    chk(level, 4'hF);
    exp_lvl = 15;
    prog(4);
    host.phase(1'b0, OFF + 5);
    chk({3'h0, active}, 4'h0);
    chk(level, 4'hF);
    chk(sink_on, 4'h0);
    exp_lvl = 15;
    host.phase(1'b1, 400);
    chk({3'h0, active}, 4'h0);
    host.phase(1'b1, 110);
    chk({3'h0, active}, 4'h1);
    chk(level, 4'hF);
    summarize();
  end
endmodule : led_pulse_ctrl_test
`default_nettype wire

// ---- led_pulse_pkg.sv ----
// Constants, timing counts and state codes for the pulse programmed
// LED current controller.
// Assumes a single 50 MHz clock; long counts are overridden at the top.
`default_nettype none
package led_pulse_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETUP_NS      = 10000;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_US        = 1500;
  localparam int OFF_CYC       = (OFF_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int APPLY_US      = 500;
  localparam int APPLY_CYC     = (APPLY_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int FILT_US       = 500;
  localparam int FILT_CYC      = (FILT_US * 1000) / CLK_PERIOD_NS;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int       CNT_W      = 17;
  localparam int       NCH        = 4;
  localparam int       LVL_W      = 4;
  localparam bit [3:0] LEVEL_FULL = 4'hF;
  localparam bit [3:0] LEVEL_DEF  = 4'hF;

  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_INIT     = 2'b01,
    ST_RUN      = 2'b10
  } state_t;

endpackage : led_pulse_pkg
`default_nettype wire

// ---- pump_if.sv ----
// Signals between the main controller and the pump ratio sequencer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pump_if;
  logic run;
  logic all_ok;
  logic supply_ok;
  logic ratio_1p5x;

  modport ctrl (output run, output all_ok, output supply_ok,
                input ratio_1p5x);
  modport pump (input run, input all_ok, input supply_ok,
                output ratio_1p5x);
endinterface : pump_if
`default_nettype wire

// ---- pump_ratio_ctrl.sv ----
// Charge pump ratio sequencer: 1X by default, 1.5X after a filter delay.
// Assumes regulation flags are synchronous and run drops at shutdown.
`timescale 1ns/1ps
`default_nettype none
module pump_ratio_ctrl #(
  parameter int unsigned FILT_CYC = led_pulse_pkg::FILT_CYC
) (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  pump_if.pump      pif
);

  logic [led_pulse_pkg::CNT_W-1:0] cnt_r;
  logic [led_pulse_pkg::CNT_W-1:0] cnt_nxt;
  logic                            ratio_r;
  logic                            ratio_nxt;

  // ****************************************************************
  // Ratio next state
  // ****************************************************************
  // Filter counts only continuous shortfall so brief dips do not switch
  always_comb
  begin
    cnt_nxt   = '0;
    ratio_nxt = ratio_r;
    if (!pif.run)
    begin
      ratio_nxt = 1'b0;
    end
    else if (!ratio_r)
    begin
      if (!pif.all_ok)
      begin
        if (cnt_r == led_pulse_pkg::CNT_W'(FILT_CYC - 1))
          ratio_nxt = 1'b1;
        else
          cnt_nxt = cnt_r + 1'b1;
      end
    end
    else if (pif.supply_ok)
    begin
      ratio_nxt = 1'b0;
    end
  end

  // Power-up in 1X
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      cnt_r   <= '0;
      ratio_r <= 1'b0;
    end
    else
    begin
      cnt_r   <= cnt_nxt;
      ratio_r <= ratio_nxt;
    end
  end

  assign pif.ratio_1p5x = ratio_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_pump_stay_1x: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (!ratio_r && pif.all_ok) |=> !ratio_r)
    else $error("pump left 1X while all channels regulate");

  sequence s_step_up;
    !ratio_r ##1 ratio_r;
  endsequence

  chk_pump_filter: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    s_step_up |-> $past(cnt_r) == led_pulse_pkg::CNT_W'(FILT_CYC - 1))
    else $error("pump went to 1.5X before the filter delay");

  chk_pump_return: assert property (
    @(posedge CLOCK) disable iff (!RST_N)
    (ratio_r && pif.supply_ok) |=> !ratio_r)
    else $error("pump stayed in 1.5X with sufficient supply");

endmodule : pump_ratio_ctrl
`default_nettype wire
